// ==== verilog/bis_pkg.sv ====
/*
  Shared constants, field layouts and state types of the boot interface selector.
  Assumes one 10 MHz system clock; timer and window counts below are in cycles of it.
*/
package bis_pkg;
  // ==========================================
  // Timing
  localparam int CLK_MHZ = 10;
  localparam int MEAS_WINDOW_US = 1024;
  localparam int MEAS_WINDOW_CYC = MEAS_WINDOW_US * CLK_MHZ;
  localparam logic [15:0] SD_TMR_MAX = 16'hffff;
  // Edge counts of the divided crystal tick (two per MHz) splitting the allowed frequencies
  localparam logic [7:0] FTH_24_16 = 8'h28;
  localparam logic [7:0] FTH_16_12 = 8'h1c;
  localparam logic [7:0] FTH_12_8 = 8'h14;
  localparam logic [7:0] FTH_8_6 = 8'h0e;
  localparam logic [7:0] FTH_6_4 = 8'h0a;
  localparam logic [7:0] FTH_4_3 = 8'h07;
  localparam logic [7:0] FTH_3_2 = 8'h05;
  // ==========================================
  // Register map
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_CMD_ADDR = 12'h008;
  localparam logic [11:0] OFF_CMD = 12'h00c;
  localparam logic [11:0] OFF_RESULT = 12'h010;
  localparam logic [11:0] OFF_BAUD = 12'h014;
  localparam int CTRL_GO_BIT = 0;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_CNT_LSB = 16;
  // ==========================================
  // Memory map and protocol values
  localparam logic [7:0] SYNC_BYTE = 8'h7f;
  localparam logic [31:0] FLASH_BASE = 32'h0800_0000;
  localparam logic [31:0] FLASH_LAST = 32'h0805_ffff;
  localparam logic [31:0] DATA_BASE = 32'h0808_0000;
  localparam logic [31:0] DATA_LAST = 32'h0808_1fff;
  localparam logic [31:0] OPT_BASE = 32'h1ff8_0000;
  localparam logic [31:0] OPT_LAST = 32'h1ff8_00ff;
  localparam logic [7:0] HALF_PAGE_BYTES = 8'h80;
  localparam logic [1:0] RDP_L0 = 2'h0;
  localparam logic [1:0] RDP_L1 = 2'h1;
  localparam logic [1:0] RDP_L2 = 2'h2;
  localparam logic [1:0] NACK_NONE = 2'h0;
  localparam logic [1:0] NACK_SINGLE = 2'h1;
  localparam logic [1:0] NACK_DOUBLE = 2'h2;
  localparam logic [2:0] WDG_PRESC_MAX = 3'h7;
  localparam logic [2:0] WDG_PRESC_RST = 3'h0;
  localparam logic [2:0] IF_ALL = 3'h7;
  localparam logic [2:0] IF_SER1 = 3'h1;
  localparam logic [2:0] IF_SER2 = 3'h2;
  localparam logic [2:0] IF_USB = 3'h4;
  localparam logic [2:0] IF_NONE = 3'h0;
  // ==========================================
  // Types
  typedef enum logic [2:0] {ST_STRAP, ST_POLL, ST_SER1, ST_SER2, ST_USB_MEAS, ST_USB, ST_APP} bis_state_t;
  typedef enum logic [1:0] {SD_IDLE, SD_START, SD_DATA} bis_sd_state_t;
  typedef enum logic [1:0] {RG_NONE, RG_FLASH, RG_DATA, RG_OPT} bis_region_t;
  typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_ERASE, OP_MASS_ERASE, OP_PROTECT, OP_UNPROTECT} bis_op_t;
  typedef struct packed {
    logic [15:0] zero;
    logic [2:0] wdg_presc;
    logic [1:0] read_protection_level;
    logic [2:0] freq_code;
    logic sysclk_ext;
    logic [2:0] if_en;
    logic boot_mode;
    logic [2:0] state;
  } bis_status_t;
  typedef struct packed {
    logic [15:0] zero_hi;
    logic [7:0] head_bytes;
    logic [1:0] zero_lo;
    logic valid;
    logic mass_erase;
    logic auto_erase;
    logic [1:0] nack;
    logic ack;
  } bis_result_t;
endpackage : bis_pkg

// ==== verilog/bis_meas_if.sv ====
/*
  Handshake between the selector and the crystal frequency meter.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface bis_meas_if;
  logic start;
  logic done;
  logic [2:0] code;
  modport ctl (output start, input done, input code);
  modport meter (input start, output done, output code);
endinterface : bis_meas_if

// ==== verilog/bis_sync_detect.sv ====
/*
  Serial receive watcher: measures the start bit, samples eight data bits at mid-bit
  and flags the synchronisation byte together with the measured bit time.
  Assumes the receive line is synchronous to the clock and idles high.
*/
`timescale 1ns/1ps
module bis_sync_detect import bis_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_en,
  input wire logic i_rx,
  output logic o_hit,
  output logic [15:0] o_bit_time
);
  bis_sd_state_t st_reg;
  logic rx_prev_reg;
  logic [15:0] tmr_reg;
  logic [2:0] bitn_reg;
  logic [7:0] shift_reg;
  wire fall = rx_prev_reg & ~i_rx;
  wire mid_bit = tmr_reg == {1'b0, o_bit_time[15:1]};
  wire end_bit = tmr_reg == o_bit_time - 16'h0001;

  // ==========================================
  // Auto-baud from the start bit, then byte capture
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= SD_IDLE;
      rx_prev_reg <= 1'b1;
      tmr_reg <= 16'h0000;
      bitn_reg <= 3'h0;
      shift_reg <= 8'h00;
      o_hit <= 1'b0;
      o_bit_time <= 16'h0000;
    end else if (i_ce) begin
      rx_prev_reg <= i_rx;
      o_hit <= 1'b0;
      if (!i_en) begin
        st_reg <= SD_IDLE;
      end else begin
        unique case (st_reg)
          SD_IDLE: if (fall) begin
            st_reg <= SD_START;
            tmr_reg <= 16'h0001;
          end
          SD_START: if (i_rx) begin
            o_bit_time <= tmr_reg;
            tmr_reg <= 16'h0000;
            bitn_reg <= 3'h0;
            st_reg <= SD_DATA;
          end else if (tmr_reg == SD_TMR_MAX) begin
            st_reg <= SD_IDLE;
          end else begin
            tmr_reg <= tmr_reg + 16'h0001;
          end
          SD_DATA: begin
            if (mid_bit) begin
              shift_reg <= {i_rx, shift_reg[7:1]};
            end
            if (end_bit) begin
              tmr_reg <= 16'h0000;
              bitn_reg <= bitn_reg + 3'h1;
              if (bitn_reg == 3'h7) begin
                st_reg <= SD_IDLE;
                o_hit <= shift_reg == SYNC_BYTE;
              end
            end else begin
              tmr_reg <= tmr_reg + 16'h0001;
            end
          end
        endcase
      end
    end
  end
endmodule : bis_sync_detect

// ==== verilog/bis_freq_meter.sv ====
/*
  Crystal frequency meter: counts rising edges of the divided crystal tick over a
  window timed by the internal clock and picks the nearest allowed frequency.
  Assumes the tick input is synchronous and divides the crystal by 512.
*/
`timescale 1ns/1ps
module bis_freq_meter import bis_pkg::*; #(
  parameter int WINDOW = MEAS_WINDOW_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_tick,
  bis_meas_if.meter m
);
  logic run_reg;
  logic tick_prev_reg;
  logic [15:0] win_reg;
  logic [7:0] edges_reg;
  wire rise = i_tick & ~tick_prev_reg;
  wire last = win_reg == 16'(WINDOW - 1);

  // Codes follow the allowed list 24,16,12,8,6,4,3,2 MHz
  function automatic logic [2:0] pick(input logic [7:0] n);
    if (n >= FTH_24_16) return 3'h0;
    if (n >= FTH_16_12) return 3'h1;
    if (n >= FTH_12_8) return 3'h2;
    if (n >= FTH_8_6) return 3'h3;
    if (n >= FTH_6_4) return 3'h4;
    if (n >= FTH_4_3) return 3'h5;
    if (n >= FTH_3_2) return 3'h6;
    return 3'h7;
  endfunction : pick

  // ==========================================
  // Measurement against the internal clock; a drifting reference skews the pick
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_reg <= 1'b0;
      tick_prev_reg <= 1'b0;
      win_reg <= 16'h0000;
      edges_reg <= 8'h00;
      m.done <= 1'b0;
      m.code <= 3'h0;
    end else if (i_ce) begin
      tick_prev_reg <= i_tick;
      m.done <= 1'b0;
      if (m.start) begin
        run_reg <= 1'b1;
        win_reg <= 16'h0000;
        edges_reg <= 8'h00;
      end else if (run_reg) begin
        win_reg <= win_reg + 16'h0001;
        if (rise && edges_reg != 8'hff) begin
          edges_reg <= edges_reg + 8'h01;
        end
        if (last) begin
          run_reg <= 1'b0;
          m.done <= 1'b1;
          m.code <= pick(edges_reg);
        end
      end
    end
  end
endmodule : bis_freq_meter

// ==== verilog/bis_top.sv ====
/*
  Boot interface selector: boot strap decode, interface polling and lock-on,
  clock and watchdog setup, memory command checking, APB register slave.
  Assumes APB master on the system clock and synchronous pin inputs.
*/
// What this block does
// - Internal RC clock for serial and selection
// - Measure crystal against internal clock
// - Jump restores loader registers to defaults
// - Watchdog prescaler at maximum while loading
// - Serial clock/handshake pins left unused
// - Poll all three interfaces until activity
// - Sync byte triggers auto-baud, serial loop
// - USB connect during polling selects USB loop
// - Selected interface disables the others
// - Later USB connect ignored in serial
// - Half-page writes, word-aligned, count a multiple of four
// - Data memory readable and writable
// - Data erase refused, auto-erase before write
// - Protect sets level one, unprotect zero
// - No mass erase; unprotect from level one erases flash
// - Serial protection refusal gives two NACKs
`timescale 1ns/1ps
module bis_top import bis_pkg::*; #(
  parameter int MEAS_WINDOW = MEAS_WINDOW_CYC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic I_BOOT_SELECT_PRIMARY,
  input wire logic I_BOOT_SELECT_SECONDARY,
  input wire logic I_FIRST_SERIAL_RECEIVE,
  input wire logic I_SECOND_SERIAL_RECEIVE,
  input wire logic I_USB_CONNECT,
  input wire logic I_EXT_CLK_TICK,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  output logic O_BOOT_MODE,
  output logic [2:0] O_IF_ENABLE,
  output logic O_SYSCLK_EXT_SEL,
  output logic [2:0] O_EXT_FREQ_CODE,
  output logic [2:0] O_WDG_PRESCALER,
  output logic [1:0] O_RDP_LEVEL,
  output logic O_MASS_ERASE_REQ,
  output logic [5:0] O_SER_AUX_OE
);
  // ==========================================
  // Decoders
  function automatic logic addr_hit(input logic [11:0] a);
    return a == OFF_CTRL || a == OFF_STATUS || a == OFF_CMD_ADDR ||
           a == OFF_CMD || a == OFF_RESULT || a == OFF_BAUD;
  endfunction : addr_hit

  function automatic bis_region_t region_of(input logic [31:0] a);
    if (a >= FLASH_BASE && a <= FLASH_LAST) return RG_FLASH;
    if (a >= DATA_BASE && a <= DATA_LAST) return RG_DATA;
    if (a >= OPT_BASE && a <= OPT_LAST) return RG_OPT;
    return RG_NONE;
  endfunction : region_of

  // ==========================================
  // State
  bis_state_t state_reg;
  bis_state_t state_next;
  bis_result_t result_reg;
  bis_result_t result_next;
  bis_status_t status_w;
  logic [31:0] addr_reg;
  logic [15:0] baud_reg;
  logic [1:0] rdp_next;
  logic mass_next;
  logic [1:0] hit;
  logic [15:0] bit_time [2];
  logic [31:0] rd_mux;

  bis_meas_if meas ();

  // ==========================================
  // APB slave: one wait state, answer registered
  wire access = I_PSEL & I_PENABLE & ~O_PREADY;
  wire done_edge = I_PSEL & I_PENABLE & O_PREADY & ~O_PSLVERR;
  wire wr_done = done_edge & I_PWRITE;
  wire go_wr = wr_done & (I_PADDR == OFF_CTRL) & I_PWDATA[CTRL_GO_BIT];
  wire cmd_wr = wr_done & (I_PADDR == OFF_CMD);
  wire addr_wr = wr_done & (I_PADDR == OFF_CMD_ADDR);

  // ==========================================
  // Interface watchers
  wire [1:0] rx_lines = {I_SECOND_SERIAL_RECEIVE, I_FIRST_SERIAL_RECEIVE};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ser
      bis_sync_detect u_det (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_en(O_IF_ENABLE[gi]),
        .i_rx(rx_lines[gi]),
        .o_hit(hit[gi]),
        .o_bit_time(bit_time[gi])
      );
    end
  endgenerate

  bis_freq_meter #(.WINDOW(MEAS_WINDOW)) u_meter (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_ce(I_CE),
    .i_tick(I_EXT_CLK_TICK),
    .m(meas.meter)
  );

  // ==========================================
  // Selection sequence
  wire strap_boot = I_BOOT_SELECT_PRIMARY & ~I_BOOT_SELECT_SECONDARY;
  wire in_session = state_reg == ST_SER1 || state_reg == ST_SER2 || state_reg == ST_USB;
  wire in_serial = state_reg == ST_SER1 || state_reg == ST_SER2;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_STRAP: state_next = strap_boot ? ST_POLL : ST_APP;
      ST_POLL: begin
        // USB wins a tie: a cable can appear at any moment of polling
        if (I_USB_CONNECT) begin
          state_next = ST_USB_MEAS;
        end else if (hit[0]) begin
          state_next = ST_SER1;
        end else if (hit[1]) begin
          state_next = ST_SER2;
        end
      end
      ST_USB_MEAS: if (meas.done) begin
        state_next = ST_USB;
      end
      ST_SER1, ST_SER2, ST_USB: if (go_wr) begin
        state_next = ST_APP;
      end
      ST_APP: state_next = ST_APP;
    endcase
  end

  assign meas.start = state_reg == ST_POLL && state_next == ST_USB_MEAS;

  wire loader_next = state_next != ST_STRAP && state_next != ST_APP;
  wire [2:0] if_en_next =
    (state_next == ST_POLL) ? IF_ALL :
    (state_next == ST_SER1) ? IF_SER1 :
    (state_next == ST_SER2) ? IF_SER2 :
    (state_next == ST_USB_MEAS || state_next == ST_USB) ? IF_USB : IF_NONE;
  wire sysclk_ext_next = state_next == ST_USB;
  wire [2:0] wdg_next = loader_next ? WDG_PRESC_MAX : WDG_PRESC_RST;
  wire [15:0] baud_next =
    (state_reg == ST_POLL && state_next == ST_SER1) ? bit_time[0] :
    (state_reg == ST_POLL && state_next == ST_SER2) ? bit_time[1] :
    go_wr ? 16'h0000 : baud_reg;

  // ==========================================
  // Memory command checking
  wire bis_op_t cmd_op = bis_op_t'(I_PWDATA[CMD_OP_LSB +: 3]);
  wire [15:0] cmd_cnt = I_PWDATA[CMD_CNT_LSB +: 16];
  wire bis_region_t cmd_rg = region_of(addr_reg);
  wire aligned = addr_reg[1:0] == 2'h0 && cmd_cnt[1:0] == 2'h0 && cmd_cnt != 16'h0000;
  wire [7:0] hp_off = addr_reg[7:0] & (HALF_PAGE_BYTES - 8'h01);
  wire [7:0] hp_room = HALF_PAGE_BYTES - hp_off;
  wire [7:0] head = (cmd_cnt < {8'h00, hp_room}) ? cmd_cnt[7:0] : hp_room;
  wire locked = O_RDP_LEVEL != RDP_L0;

  always_comb begin
    logic acc;
    logic rdp_refuse;
    acc = 1'b0;
    rdp_refuse = 1'b0;
    result_next = '0;
    result_next.valid = 1'b1;
    rdp_next = O_RDP_LEVEL;
    mass_next = 1'b0;
    if (in_session) begin
      unique case (cmd_op)
        OP_READ: begin
          rdp_refuse = locked;
          acc = !locked && cmd_rg != RG_NONE;
        end
        OP_WRITE: begin
          rdp_refuse = locked;
          acc = !locked && aligned && cmd_rg != RG_NONE;
          result_next.auto_erase = acc && cmd_rg == RG_DATA;
          result_next.head_bytes = (acc && cmd_rg == RG_FLASH) ? head : 8'h00;
        end
        OP_ERASE: acc = cmd_rg == RG_FLASH;
        OP_MASS_ERASE: acc = 1'b0;
        OP_PROTECT: begin
          acc = O_RDP_LEVEL != RDP_L2;
          rdp_next = acc ? RDP_L1 : O_RDP_LEVEL;
        end
        OP_UNPROTECT: begin
          acc = O_RDP_LEVEL != RDP_L2;
          rdp_next = acc ? RDP_L0 : O_RDP_LEVEL;
          mass_next = acc && O_RDP_LEVEL == RDP_L1;
        end
        default: acc = 1'b0;
      endcase
    end
    result_next.ack = acc;
    result_next.mass_erase = mass_next;
    result_next.nack = acc ? NACK_NONE : (rdp_refuse && in_serial) ? NACK_DOUBLE : NACK_SINGLE;
  end

  // ==========================================
  // Read view
  always_comb begin
    status_w = '0;
    status_w.state = state_reg;
    status_w.boot_mode = O_BOOT_MODE;
    status_w.if_en = O_IF_ENABLE;
    status_w.sysclk_ext = O_SYSCLK_EXT_SEL;
    status_w.freq_code = O_EXT_FREQ_CODE;
    status_w.read_protection_level = O_RDP_LEVEL;
    status_w.wdg_presc = O_WDG_PRESCALER;
  end

  assign rd_mux =
    (I_PADDR == OFF_STATUS) ? status_w :
    (I_PADDR == OFF_CMD_ADDR) ? addr_reg :
    (I_PADDR == OFF_RESULT) ? result_reg :
    (I_PADDR == OFF_BAUD) ? {16'h0000, baud_reg} : 32'h0000_0000;

  // ==========================================
  // Flops
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
    end else if (I_CE) begin
      O_PREADY <= access;
      O_PSLVERR <= access & ~addr_hit(I_PADDR);
      O_PRDATA <= (access & ~I_PWRITE & addr_hit(I_PADDR)) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= ST_STRAP;
      O_BOOT_MODE <= 1'b0;
      O_IF_ENABLE <= IF_NONE;
      O_SYSCLK_EXT_SEL <= 1'b0;
      O_WDG_PRESCALER <= WDG_PRESC_RST;
      baud_reg <= 16'h0000;
      O_SER_AUX_OE <= 6'h00;
    end else if (I_CE) begin
      state_reg <= state_next;
      if (state_reg == ST_STRAP) begin
        O_BOOT_MODE <= strap_boot;
      end
      O_IF_ENABLE <= if_en_next;
      O_SYSCLK_EXT_SEL <= sysclk_ext_next;
      O_WDG_PRESCALER <= wdg_next;
      baud_reg <= baud_next;
      // Clock and handshake pins stay released for other functions
      O_SER_AUX_OE <= 6'h00;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_EXT_FREQ_CODE <= 3'h0;
      addr_reg <= 32'h0000_0000;
      result_reg <= '0;
      O_RDP_LEVEL <= RDP_L0;
      O_MASS_ERASE_REQ <= 1'b0;
    end else if (I_CE) begin
      if (meas.done) begin
        O_EXT_FREQ_CODE <= meas.code;
      end else if (go_wr) begin
        O_EXT_FREQ_CODE <= 3'h0;
      end
      if (addr_wr) begin
        addr_reg <= I_PWDATA;
      end else if (go_wr) begin
        addr_reg <= 32'h0000_0000;
      end
      if (cmd_wr) begin
        result_reg <= result_next;
        O_RDP_LEVEL <= rdp_next;
      end else if (go_wr) begin
        result_reg <= '0;
      end
      O_MASS_ERASE_REQ <= cmd_wr & mass_next;
    end
  end
endmodule : bis_top

// ==== tb/bis_top_sva.sv ====
/*
  Checker for the boot interface selector: port-level timing and lock-on rules.
  Assumes one clock domain and the top module's port names; bound below.
*/
`timescale 1ns/1ps
module bis_top_sva import bis_pkg::*; #(
  parameter int MEAS_WINDOW = MEAS_WINDOW_CYC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_USB_CONNECT,
  input wire logic O_PREADY,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PSLVERR,
  input wire logic O_BOOT_MODE,
  input wire logic [2:0] O_IF_ENABLE,
  input wire logic O_SYSCLK_EXT_SEL,
  input wire logic [2:0] O_WDG_PRESCALER,
  input wire logic [1:0] O_RDP_LEVEL,
  input wire logic O_MASS_ERASE_REQ,
  input wire logic [5:0] O_SER_AUX_OE
);
  // ==========================================
  // Sequences
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  sequence s_access;
    I_CE && I_PSEL && I_PENABLE && !O_PREADY;
  endsequence
  sequence s_erase_done;
    !O_MASS_ERASE_REQ && O_RDP_LEVEL == RDP_L0;
  endsequence
  // ==========================================
  // Properties
  property p_apb_answer;
    s_access ##1 I_CE |-> O_PREADY;
  endproperty
  property p_pready_pulse;
    O_PREADY && I_CE |=> !O_PREADY;
  endproperty
  property p_slverr;
    O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0;
  endproperty
  property p_aux_free;
    O_SER_AUX_OE == 6'h00;
  endproperty
  property p_ext_clk;
    O_SYSCLK_EXT_SEL |-> O_IF_ENABLE == IF_USB;
  endproperty
  property p_wdg_max;
    O_IF_ENABLE != IF_NONE |-> O_WDG_PRESCALER == WDG_PRESC_MAX;
  endproperty
  property p_boot_strap;
    !O_BOOT_MODE |-> O_IF_ENABLE == IF_NONE;
  endproperty
  property p_lock;
    $onehot(O_IF_ENABLE) |=> O_IF_ENABLE == $past(O_IF_ENABLE) || O_IF_ENABLE == IF_NONE;
  endproperty
  property p_usb_wins;
    I_CE && I_USB_CONNECT && O_IF_ENABLE == IF_ALL |=> O_IF_ENABLE != IF_SER1 && O_IF_ENABLE != IF_SER2;
  endproperty
  property p_rdp_levels;
    $changed(O_RDP_LEVEL) |-> O_RDP_LEVEL != RDP_L2;
  endproperty
  property p_mass_erase;
    O_MASS_ERASE_REQ |=> s_erase_done;
  endproperty
  // ==========================================
  // Assertions
  a_apb_answer: assert property (p_apb_answer) else $error("pready late");
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready too long");
  a_slverr: assert property (p_slverr) else $error("slverr without pready or zero data");
  a_aux_free: assert property (p_aux_free) else $error("aux pin driven");
  a_ext_clk: assert property (p_ext_clk) else $error("crystal clock outside usb");
  a_wdg_max: assert property (p_wdg_max) else $error("watchdog not at max");
  a_boot_strap: assert property (p_boot_strap) else $error("interface on without boot mode");
  a_lock: assert property (p_lock) else $error("selection changed");
  a_usb_wins: assert property (p_usb_wins) else $error("serial chosen over usb");
  a_rdp_levels: assert property (p_rdp_levels) else $error("level two set by command");
  a_mass_erase: assert property (p_mass_erase) else $error("erase pulse wrong");
endmodule : bis_top_sva

bind bis_top bis_top_sva #(.MEAS_WINDOW(MEAS_WINDOW)) u_sva (
  .I_CLK_SYS(I_CLK_SYS),
  .I_RST_N(I_RST_N),
  .I_CE(I_CE),
  .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE),
  .I_USB_CONNECT(I_USB_CONNECT),
  .O_PREADY(O_PREADY),
  .O_PRDATA(O_PRDATA),
  .O_PSLVERR(O_PSLVERR),
  .O_BOOT_MODE(O_BOOT_MODE),
  .O_IF_ENABLE(O_IF_ENABLE),
  .O_SYSCLK_EXT_SEL(O_SYSCLK_EXT_SEL),
  .O_WDG_PRESCALER(O_WDG_PRESCALER),
  .O_RDP_LEVEL(O_RDP_LEVEL),
  .O_MASS_ERASE_REQ(O_MASS_ERASE_REQ),
  .O_SER_AUX_OE(O_SER_AUX_OE)
);

// ==== tb/bis_host_model.sv ====
/*
  Programming host model: serial frames on either receive line, USB presence, crystal tick.
  Assumes the system clock; all lines change just after a rising edge.
*/
`timescale 1ns/1ps
module bis_host_model (
  input wire logic i_clk,
  output logic o_rx1,
  output logic o_rx2,
  output logic o_usb,
  output logic o_tick
);
  int tick_half = 0;
  int tick_cnt = 0;
  // Unused receive lines idle at a steady high, never floating
  initial begin
    o_rx1 = 1'b1;
    o_rx2 = 1'b1;
    o_usb = 1'b0;
    o_tick = 1'b0;
  end
  // ==========================================
  // Crystal divided by 512, stands still until started
  always @(posedge i_clk) begin
    if (tick_half > 0) begin
      if (tick_cnt >= tick_half - 1) begin
        o_tick <= ~o_tick;
        tick_cnt <= 0;
      end else begin
        tick_cnt <= tick_cnt + 1;
      end
    end
  end
  task automatic set_tick(input int half);
    tick_half = half;
  endtask : set_tick
  task automatic set_usb(input logic v);
    @(posedge i_clk);
    o_usb <= v;
  endtask : set_usb
  // Start low, eight bits LSB first, stop high; each bit t cycles
  task automatic send_byte(input int port, input logic [7:0] b, input int t);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      if (port == 0) o_rx1 <= fr[i];
      else o_rx2 <= fr[i];
      repeat (t - 1) @(posedge i_clk);
    end
    repeat (2 * t) @(posedge i_clk);
  endtask : send_byte
endmodule : bis_host_model

// ==== tb/boot_interface_selector_tb_top.sv ====
/*
  Testbench of the boot interface selector: APB register tasks and scenario calls.
  Assumes the host model for pin traffic and the bound checker.
*/
`timescale 1ns/1ps
module boot_interface_selector_tb_top;
  import bis_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic boot_pri = 1'b0;
  logic boot_sec = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire rx1, rx2, usb, tick;
  logic pready, pslverr, boot_mode, ext_sel, erase_req;
  logic [31:0] prdata;
  logic [2:0] if_en, freq, wdg;
  logic [1:0] read_protection_level;
  logic [5:0] aux_oe;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_erase = 0;
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (erase_req === 1'b1) n_erase++;
  bis_host_model HOST (.i_clk(clk_sys), .o_rx1(rx1), .o_rx2(rx2), .o_usb(usb), .o_tick(tick));
  bis_top DUT (.I_CLK_SYS(clk_sys), .I_RST_N(rst_n), .I_CE(1'b1), .I_BOOT_SELECT_PRIMARY(boot_pri),
    .I_BOOT_SELECT_SECONDARY(boot_sec), .I_FIRST_SERIAL_RECEIVE(rx1), .I_SECOND_SERIAL_RECEIVE(rx2),
    .I_USB_CONNECT(usb), .I_EXT_CLK_TICK(tick), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr),
    .O_BOOT_MODE(boot_mode), .O_IF_ENABLE(if_en), .O_SYSCLK_EXT_SEL(ext_sel), .O_EXT_FREQ_CODE(freq),
    .O_WDG_PRESCALER(wdg), .O_RDP_LEVEL(read_protection_level), .O_MASS_ERASE_REQ(erase_req), .O_SER_AUX_OE(aux_oe));
  // ==========================================
  // Tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Waits for the slave's answer; the bound only cuts a hang
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk_sys);
    if (k == 20) begin
      n_mismatch++;
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q & mask, exp);
  endtask : rd_chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic cmd(input logic [31:0] a, input logic [2:0] op, input logic [15:0] cnt, input logic [31:0] exp,
    input logic [31:0] mask);
    wr(OFF_CMD_ADDR, a);
    wr(OFF_CMD, {cnt, 13'h0, op});
    rd_chk(OFF_RESULT, exp, mask);
  endtask : cmd
  task automatic do_reset(input logic pri, input logic sec);
    rst_n <= 1'b0;
    boot_pri <= pri;
    boot_sec <= sec;
    repeat (12) @(posedge clk_sys);
    check(32'({boot_mode, if_en, wdg, read_protection_level, ext_sel}), 32'h0);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : do_reset
  // ==========================================
  // Scenarios
  initial begin
    logic [31:0] q;
    logic e;
    int k;
    do_reset(1'b1, 1'b1);
    rd_chk(OFF_STATUS, 32'h6, 32'hff);
    do_reset(1'b1, 1'b0);
    rd_chk(OFF_STATUS, 32'he079, 32'hffff);
    cmd(FLASH_BASE, OP_READ, 16'h4, 32'h22, 32'hff);
    HOST.send_byte(1, 8'h55, 8);
    check(32'(if_en), 32'(IF_ALL));
    HOST.send_byte(0, SYNC_BYTE, 8);
    rd_chk(OFF_STATUS, 32'he01a, 32'hffff);
    rd_chk(OFF_BAUD, 32'h8, 32'hffff);
    HOST.set_usb(1'b1);
    HOST.send_byte(1, SYNC_BYTE, 8);
    rd_chk(OFF_STATUS, 32'he01a, 32'hffff);
    check(32'(aux_oe), 32'h0);
    cmd(32'h0800_0004, OP_WRITE, 16'h8, 32'h21, 32'hff);
    cmd(32'h0800_0002, OP_WRITE, 16'h8, 32'h22, 32'hff);
    cmd(FLASH_BASE, OP_WRITE, 16'h6, 32'h22, 32'hff);
    cmd(DATA_BASE, OP_WRITE, 16'h4, 32'h29, 32'hff);
    cmd(DATA_LAST - 32'h3, OP_READ, 16'h4, 32'h21, 32'hff);
    cmd(DATA_BASE, OP_ERASE, 16'h4, 32'h22, 32'hff);
    cmd(FLASH_BASE, OP_ERASE, 16'h4, 32'h21, 32'hff);
    cmd(FLASH_BASE, OP_MASS_ERASE, 16'h0, 32'h22, 32'hff);
    cmd(OPT_BASE, OP_PROTECT, 16'h0, 32'h21, 32'h27);
    check(32'(read_protection_level), 32'(RDP_L1));
    cmd(FLASH_BASE, OP_READ, 16'h4, 32'h24, 32'hff);
    cmd(FLASH_BASE, OP_WRITE, 16'h4, 32'h24, 32'hff);
    cmd(OPT_BASE, OP_UNPROTECT, 16'h0, 32'h21, 32'h27);
    check(32'(read_protection_level), 32'(RDP_L0));
    check(32'(n_erase), 32'h1);
    apb(1'b0, 12'h018, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    wr(OFF_CTRL, 32'h1);
    rd_chk(OFF_STATUS, 32'h000e, 32'hffff);
    rd_chk(OFF_BAUD, 32'h0, 32'hffffffff);
    rd_chk(OFF_CMD_ADDR, 32'h0, 32'hffffffff);
    HOST.set_usb(1'b0);
    // Crystal at 8 MHz: tick period 640 cycles of the 100 ns clock
    HOST.set_tick(320);
    do_reset(1'b1, 1'b0);
    HOST.set_usb(1'b1);
    repeat (4) @(posedge clk_sys);
    check(32'(ext_sel), 32'h0);
    for (k = 0; k < 12000 && ext_sel !== 1'b1; k++) @(posedge clk_sys);
    if (k == 12000) n_mismatch++;
    check(32'(freq), 32'h3);
    rd_chk(OFF_STATUS, 32'h00cd, 32'h00ff);
    complete_run();
  end
endmodule : boot_interface_selector_tb_top
